// ==== core/gate_seq_top.sv ====
// Drive-side read/write gate sequencer with register access
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "gate_params.svh"

module gate_seq_top #(
  parameter int LOCK_BITS = `GS_LOCK_BITS
) (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire gate_pkg::reg_addr_t awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire gate_pkg::reg_addr_t araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                link_clk,
  input  wire logic                read_gate,
  input  wire logic                write_gate,
  input  wire logic                write_data,
  input  wire logic                medium_rd_data,
  output logic                     read_data_out,
  output logic                     medium_wr_en,
  output logic                     medium_wr_data
);
  import gate_pkg::*;

  localparam int WD_N = `GS_ENC_DLY - `GS_SYNC_STG - 1;
  localparam int RD_N = `GS_RD_DLY - `GS_SYNC_STG - 1;

  generate
    if (LOCK_BITS < 1 || LOCK_BITS + `GS_SYNC_STG + 1 > `GS_PRE_BITS) begin : g_bad
      $error("LOCK_BITS must leave lock inside the preamble");
    end
  endgenerate

  reg_if rif ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and register file (sys_clk)
  axil_slave u_bus (
    .sys_clk (sys_clk),
    .srst    (srst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif.bus)
  );

  logic [1:0]  ctrl_reg;
  logic [31:0] lock_events_reg;
  logic [31:0] write_events_reg;
  logic        lock_tgl_d_reg;
  logic        wr_tgl_d_reg;
  logic        st_locked;
  logic        st_writing;
  logic        st_overlap;
  logic        st_lock_tgl;
  logic        st_wr_tgl;
  logic        lock_evt;
  logic        wr_evt;
  reg_addr_t   wa;
  reg_addr_t   ra;

  assign wa       = {rif.waddr[`GS_ADDR_W-1:2], 2'b00};
  assign ra       = {rif.raddr[`GS_ADDR_W-1:2], 2'b00};
  assign lock_evt = st_lock_tgl ^ lock_tgl_d_reg;
  assign wr_evt   = st_wr_tgl ^ wr_tgl_d_reg;

  always_comb begin
    rif.werr = !(wa == `GS_CTRL_OFS || wa == `GS_STAT_OFS ||
                 wa == `GS_LCNT_OFS || wa == `GS_WCNT_OFS);
    rif.rerr = 1'b0;
    unique case (ra)
      `GS_CTRL_OFS: rif.rdata = {30'h0000_0000, ctrl_reg};
      `GS_STAT_OFS: rif.rdata = {29'h0000_0000, st_overlap, st_writing, st_locked};
      `GS_LCNT_OFS: rif.rdata = lock_events_reg;
      `GS_WCNT_OFS: rif.rdata = write_events_reg;
      default: begin
        rif.rdata = 32'h0000_0000;
        rif.rerr  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg <= `GS_CTRL_RST;
    end else if (rif.wr_stb && wa == `GS_CTRL_OFS && rif.wstrb[0]) begin
      ctrl_reg <= rif.wdata[1:0];
    end
  end

  // Event counters: a write clears, but an event in the same cycle still counts
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lock_tgl_d_reg   <= 1'b0;
      wr_tgl_d_reg     <= 1'b0;
      lock_events_reg  <= 32'h0000_0000;
      write_events_reg <= 32'h0000_0000;
    end else begin
      lock_tgl_d_reg <= st_lock_tgl;
      wr_tgl_d_reg   <= st_wr_tgl;
      if (rif.wr_stb && wa == `GS_LCNT_OFS) begin
        lock_events_reg <= {31'h0000_0000, lock_evt};
      end else if (lock_evt) begin
        lock_events_reg <= lock_events_reg + 32'h0000_0001;
      end
      if (rif.wr_stb && wa == `GS_WCNT_OFS) begin
        write_events_reg <= {31'h0000_0000, wr_evt};
      end else if (wr_evt) begin
        write_events_reg <= write_events_reg + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings; lock and write starts travel as toggles so none is lost
  logic lrst;
  logic ren_s;
  logic wen_s;
  logic rg_s;
  logic wg_s;
  logic wd_s;
  logic rd_s;
  logic locked_reg;
  logic lock_tgl_reg;
  logic wr_tgl_reg;
  logic overlap_reg;

  bit_sync #(.WIDTH(3)) u_ctl_sync (
    .clk (link_clk),
    .d   ({srst, ctrl_reg[`GS_CTRL_RDEN], ctrl_reg[`GS_CTRL_WREN]}),
    .q   ({lrst, ren_s, wen_s})
  );

  bit_sync #(.WIDTH(4)) u_pin_sync (
    .clk (link_clk),
    .d   ({read_gate, write_gate, write_data, medium_rd_data}),
    .q   ({rg_s, wg_s, wd_s, rd_s})
  );

  bit_sync #(.WIDTH(5)) u_st_sync (
    .clk (sys_clk),
    .d   ({locked_reg, medium_wr_en, overlap_reg, lock_tgl_reg, wr_tgl_reg}),
    .q   ({st_locked, st_writing, st_overlap, st_lock_tgl, st_wr_tgl})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read side (link_clk): lock on the preamble, then pass delayed data
  rd_state_t       rd_state_reg;
  logic [7:0]      lock_cnt_reg;
  logic [RD_N-1:0] rd_pipe_reg;
  logic            rd_ok;

  // A write gate overlapping the read gate holds the separator off
  assign rd_ok = rg_s && ren_s && !wg_s;

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      rd_state_reg <= RD_IDLE;
      lock_cnt_reg <= 8'h00;
      locked_reg   <= 1'b0;
      lock_tgl_reg <= 1'b0;
    end else begin
      unique case (rd_state_reg)
        RD_IDLE: begin
          lock_cnt_reg <= 8'h00;
          if (rd_ok) begin
            rd_state_reg <= RD_LOCKING;
          end
        end
        RD_LOCKING: begin
          if (!rd_ok) begin
            rd_state_reg <= RD_IDLE;
          end else if (lock_cnt_reg == 8'(LOCK_BITS - 1)) begin
            rd_state_reg <= RD_LOCKED;
            locked_reg   <= 1'b1;
            lock_tgl_reg <= !lock_tgl_reg;
          end else begin
            lock_cnt_reg <= lock_cnt_reg + 8'h01;
          end
        end
        RD_LOCKED: begin
          if (!rd_ok) begin
            rd_state_reg <= RD_IDLE;
            locked_reg   <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      rd_pipe_reg   <= '0;
      read_data_out <= 1'b0;
      overlap_reg   <= 1'b0;
    end else begin
      rd_pipe_reg   <= {rd_pipe_reg[RD_N-2:0], rd_s};
      // Held at zero until lock so the adapter never sees garbage
      read_data_out <= locked_reg ? rd_pipe_reg[RD_N-1] : 1'b0;
      overlap_reg   <= rg_s && wg_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write side (link_clk): driver turn-on, splice zeros, encoder delay
  logic [2:0]      turnon_cnt_reg;
  logic [WD_N-1:0] wd_pipe_reg;

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      turnon_cnt_reg <= 3'h0;
      medium_wr_en   <= 1'b0;
      wr_tgl_reg     <= 1'b0;
    end else if (!wg_s || !wen_s) begin
      turnon_cnt_reg <= 3'h0;
      medium_wr_en   <= 1'b0;
    end else if (!medium_wr_en) begin
      if (turnon_cnt_reg == 3'(`GS_TURNON - `GS_SYNC_STG - 1)) begin
        medium_wr_en <= 1'b1;
        wr_tgl_reg   <= !wr_tgl_reg;
      end else begin
        turnon_cnt_reg <= turnon_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      wd_pipe_reg    <= '0;
      medium_wr_data <= 1'b0;
    end else begin
      wd_pipe_reg    <= {wd_pipe_reg[WD_N-2:0], wd_s};
      // Splice bits are zeros from the encoder itself, not adapter data
      medium_wr_data <= medium_wr_en ? wd_pipe_reg[WD_N-1] : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_lock_in_preamble;
    @(posedge link_clk) disable iff (lrst)
    $rose(rg_s) && ren_s && !wg_s |-> ##[1:88] (locked_reg || !rd_ok);
  endproperty
  a_lock_in_preamble: assert property (p_lock_in_preamble)
    else $error("read data not valid within preamble");

  property p_zero_before_lock;
    @(posedge link_clk) disable iff (lrst)
    !$past(locked_reg) |-> !read_data_out;
  endproperty
  a_zero_before_lock: assert property (p_zero_before_lock)
    else $error("read data not held low before lock");

  property p_read_delay;
    @(posedge link_clk) disable iff (lrst)
    $past(locked_reg) && $past(rg_s, 7) |-> read_data_out == $past(rd_s, 7);
  endproperty
  a_read_delay: assert property (p_read_delay)
    else $error("read data delay is not nine bits");

  property p_turnon_max;
    @(posedge link_clk) disable iff (lrst)
    $rose(wg_s) && wen_s |-> ##[1:4] (medium_wr_en || !wg_s || !wen_s);
  endproperty
  a_turnon_max: assert property (p_turnon_max)
    else $error("write driver turn-on too slow");

  property p_turnon_cause;
    @(posedge link_clk) disable iff (lrst)
    $rose(medium_wr_en) |-> $past(wg_s, 4) && $past(wg_s, 1) && $past(wen_s);
  endproperty
  a_turnon_cause: assert property (p_turnon_cause)
    else $error("write driver on without a held gate");

  property p_enc_delay;
    @(posedge link_clk) disable iff (lrst)
    $past(medium_wr_en) |-> medium_wr_data == $past(wd_s, 6);
  endproperty
  a_enc_delay: assert property (p_enc_delay)
    else $error("encoder delay is not eight bits");

  property p_splice_zero;
    @(posedge link_clk) disable iff (lrst)
    !$past(medium_wr_en) |-> !medium_wr_data;
  endproperty
  a_splice_zero: assert property (p_splice_zero)
    else $error("splice bits not zero");

  property p_cnt_clear;
    @(posedge sys_clk) disable iff (srst)
    rif.wr_stb && wa == `GS_LCNT_OFS |=> lock_events_reg == {31'h0000_0000, $past(lock_evt)};
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("lock counter clear lost an event");
endmodule

// ==== core/gate_params.svh ====
// Offsets, fields, reset values and timing counts of the gate sequencer
`ifndef GATE_PARAMS_SVH
`define GATE_PARAMS_SVH
`define GS_ADDR_W     5
`define GS_CTRL_OFS   5'h00
`define GS_STAT_OFS   5'h04
`define GS_LCNT_OFS   5'h08
`define GS_WCNT_OFS   5'h0C
`define GS_CTRL_RST   2'h3
`define GS_CTRL_RDEN  0
`define GS_CTRL_WREN  1
`define GS_STAT_LOCK  0
`define GS_STAT_WR    1
`define GS_STAT_OVL   2
`define GS_RESP_OK    2'h0
`define GS_RESP_ERR   2'h2
`define GS_SYNC_STG   2
`define GS_PRE_BITS   88
`define GS_LOCK_BITS  64
`define GS_RD_DLY     9
`define GS_ENC_DLY    8
`define GS_TURNON     6
`endif

// ==== core/gate_pkg.sv ====
// Types shared by the gate sequencer modules
`include "gate_params.svh"
package gate_pkg;
  typedef logic [`GS_ADDR_W-1:0] reg_addr_t;
  typedef enum logic [2:0] {
    RD_IDLE    = 3'b001,
    RD_LOCKING = 3'b010,
    RD_LOCKED  = 3'b100
  } rd_state_t;
endpackage

// ==== core/reg_if.sv ====
// Register access strobes between the bus slave and the register file
`timescale 1ns/100ps
interface reg_if;
  import gate_pkg::*;
  logic        wr_stb;
  reg_addr_t   waddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        werr;
  reg_addr_t   raddr;
  logic [31:0] rdata;
  logic        rerr;
  modport bus  (output wr_stb, waddr, wdata, wstrb, raddr, input werr, rdata, rerr);
  modport regs (input wr_stb, waddr, wdata, wstrb, raddr, output werr, rdata, rerr);
endinterface

// ==== core/bit_sync.sv ====
// Two-flop synchroniser, one chain per bit
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  generate
    if (WIDTH < 1) begin : g_bad
      $error("bit_sync needs WIDTH of at least 1");
    end
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      always_ff @(posedge clk) begin
        meta_reg <= d[i];
        q[i]     <= meta_reg;
      end
    end
  endgenerate
endmodule

// ==== core/axil_slave.sv ====
// AXI4-Lite slave front end; one write and one read in flight
`timescale 1ns/100ps
`include "gate_params.svh"
module axil_slave (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire gate_pkg::reg_addr_t awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire gate_pkg::reg_addr_t araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  reg_if.bus                       rif
);
  import gate_pkg::*;
  logic      aw_got_reg;
  logic      w_got_reg;
  logic      ar_got_reg;
  reg_addr_t waddr_reg;
  reg_addr_t raddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic      do_wr;

  assign do_wr      = aw_got_reg && w_got_reg && !bvalid;
  assign rif.wr_stb = do_wr;
  assign rif.waddr  = waddr_reg;
  assign rif.wdata  = wdata_reg;
  assign rif.wstrb  = wstrb_reg;
  assign rif.raddr  = raddr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address and data are taken independently, in either order
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      awready    <= 1'b0;
      aw_got_reg <= 1'b0;
      waddr_reg  <= '0;
    end else if (awvalid && awready) begin
      awready    <= 1'b0;
      aw_got_reg <= 1'b1;
      waddr_reg  <= awaddr;
    end else if (do_wr) begin
      aw_got_reg <= 1'b0;
    end else begin
      awready <= awvalid && !aw_got_reg && !awready;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wready    <= 1'b0;
      w_got_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (wvalid && wready) begin
      wready    <= 1'b0;
      w_got_reg <= 1'b1;
      wdata_reg <= wdata;
      wstrb_reg <= wstrb;
    end else if (do_wr) begin
      w_got_reg <= 1'b0;
    end else begin
      wready <= wvalid && !w_got_reg && !wready;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp  <= `GS_RESP_OK;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= rif.werr ? `GS_RESP_ERR : `GS_RESP_OK;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read: data is latched one cycle after the address is taken
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      arready    <= 1'b0;
      ar_got_reg <= 1'b0;
      raddr_reg  <= '0;
      rvalid     <= 1'b0;
      rdata      <= 32'h0000_0000;
      rresp      <= `GS_RESP_OK;
    end else begin
      if (arvalid && arready) begin
        arready    <= 1'b0;
        ar_got_reg <= 1'b1;
        raddr_reg  <= araddr;
      end else begin
        arready <= arvalid && !ar_got_reg && !arready && !rvalid;
      end
      if (ar_got_reg && !rvalid) begin
        rvalid     <= 1'b1;
        rdata      <= rif.rdata;
        rresp      <= rif.rerr ? `GS_RESP_ERR : `GS_RESP_OK;
        ar_got_reg <= 1'b0;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== verif/adapter_model.sv ====
// Adapter-side partner: gates, write data and head bits on the bit clock
`timescale 1ns/100ps
module adapter_model (
  input  wire logic link_clk,
  output logic      read_gate,
  output logic      write_gate,
  output logic      write_data,
  output logic      medium_rd_data
);
  localparam logic [7:0] SYNC_BYTE = 8'hA1;
  logic [7:0] hcnt = 8'h00;
  realtime    wg_fall = -1.0e6;
  initial begin
    read_gate = 1'b0;
    write_gate = 1'b0;
    write_data = 1'b0;
    medium_rd_data = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Head bits change irregularly so a wrong delay cannot match
  always @(posedge link_clk) begin
    hcnt <= hcnt + 8'h01;
    medium_rd_data <= hcnt[0] ^ hcnt[3] ^ hcnt[5];
  end
  // Intervals are counted on the bit clock, except the 10000 ns gap after a write gate falls
  task automatic bits(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic read_field(input int n);
    do bits(1); while ($realtime - wg_fall < 10000.0);
    read_gate <= 1'b1;
    bits(n);
    read_gate <= 1'b0;
  endtask
  // Preamble, sync, data and check bytes, pad; gate kept one byte longer
  task automatic write_field(input int n);
    int last;
    last = 96 + 8 * n;
    bits(3);
    write_gate <= 1'b1;
    for (int i = 0; i < last + 8; i++) begin
      if (i < 88) write_data <= 1'b0;
      else if (i < 96) write_data <= SYNC_BYTE[95 - i];
      else if (i < last) write_data <= i[0] ^ i[2] ^ i[4];
      else write_data <= 1'b0;
      bits(1);
    end
    bits(8);
    write_gate <= 1'b0;
    wg_fall = $realtime;
  endtask
  // Deliberate gate overlap, only for the refusal scenario
  task automatic overlap(input int n);
    bits(1);
    read_gate <= 1'b1;
    write_gate <= 1'b1;
    bits(n);
    read_gate <= 1'b0;
    write_gate <= 1'b0;
    wg_fall = $realtime;
  endtask
endmodule

// ==== verif/gate_seq_top_tb.sv ====
// Self-checking bench for the gate sequencer: register bus and link timing
`timescale 1ns/100ps
`include "gate_params.svh"
module gate_seq_top_tb;
  import gate_pkg::*;
  localparam logic [1:0] OK = `GS_RESP_OK;
  localparam logic [1:0] ERR = `GS_RESP_ERR;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        srst = 1'b1;
  reg_addr_t   awaddr = '0;
  reg_addr_t   araddr = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd;
  logic        read_gate, write_gate, write_data, medium_rd_data;
  logic        read_data_out, medium_wr_en, medium_wr_data;
  logic [15:0] mh = '0, wh = '0;
  int          rg_n = 0, rl_n = 0, wg_n = 0, wl_n = 0;
  logic        lock_exp = 1'b1, wp = 1'b0;
  int          n_errors = 0, checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  always #3 link_clk = ~link_clk;
  gate_seq_top #(.LOCK_BITS(8)) dut_u (.sys_clk, .srst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .link_clk, .read_gate, .write_gate,
    .write_data, .medium_rd_data, .read_data_out, .medium_wr_en, .medium_wr_data);
  adapter_model adp_u (.link_clk, .read_gate, .write_gate, .write_data, .medium_rd_data);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic axi_write(input reg_addr_t a, input logic [31:0] d, input logic [1:0] er,
                           input logic [3:0] st = 4'hF);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk_word("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  // A nonzero lag holds rready off so the answer must stand until it is taken
  task automatic axi_read(input reg_addr_t a, output logic [31:0] d, input logic [1:0] er,
                          input int lag = 0);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) begin
        repeat (lag) @(posedge sys_clk);
        chk_bit("rvalid_hold", 1'b1, rvalid);
        rready <= 1'b1;
      end
    end while (!(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    chk_word("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  // Status sampled mid-transfer; it lags the link by a few cycles
  task automatic stat_at(input int n, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] s;
    repeat (n) @(posedge sys_clk);
    axi_read(`GS_STAT_OFS, s, OK);
    chk_word("status", exp, s & mask);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Link watch; idle checks wait out the synchroniser and turn-off lag
  always @(posedge link_clk) begin
    if (rg_n >= 88) chk_bit("rd_bit", lock_exp & mh[8], read_data_out);
    if (rl_n >= 6) chk_bit("rd_idle", 1'b0, read_data_out);
    if (wg_n >= 7 || wl_n >= 6) begin
      chk_bit("wr_en", wg_n >= 7 && !wp, medium_wr_en);
      chk_bit("wr_bit", wg_n >= 7 && !wp && wh[7], medium_wr_data);
    end
    mh = {mh[14:0], medium_rd_data};
    wh = {wh[14:0], write_data};
    rg_n = read_gate ? rg_n + 1 : 0;
    rl_n = read_gate ? 0 : rl_n + 1;
    wg_n = write_gate ? wg_n + 1 : 0;
    wl_n = write_gate ? 0 : wl_n + 1;
  end
  task automatic report_and_stop();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    axi_read(`GS_CTRL_OFS, rd, OK);
    chk_word("ctrl_rst", 32'h3, rd);
    for (int a = 4; a < 16; a += 4) begin
      axi_read(reg_addr_t'(a), rd, OK);
      chk_word("ro_rst", 32'h0, rd);
    end
    axi_read(5'h10, rd, ERR);
    chk_word("unmapped", 32'h0, rd);
    axi_write(5'h14, 32'hF, ERR);
    axi_write(`GS_STAT_OFS, 32'h7, OK);
    axi_read(`GS_STAT_OFS, rd, OK);
    chk_word("stat_ro", 32'h0, rd);
    fork
      adp_u.read_field(300);
      stat_at(40, 32'h1, 32'h7);
    join
    fork
      adp_u.write_field(4);
      stat_at(30, 32'h2, 32'h7);
    join
    axi_read(`GS_LCNT_OFS, rd, OK);
    chk_word("lock_cnt", 32'h1, rd);
    axi_read(`GS_WCNT_OFS, rd, OK);
    chk_word("wr_cnt", 32'h1, rd);
    axi_write(`GS_LCNT_OFS, 32'h0, OK);
    axi_read(`GS_LCNT_OFS, rd, OK);
    chk_word("lock_clr", 32'h0, rd);
    adp_u.read_field(200);
    axi_write(`GS_CTRL_OFS, 32'h1, OK);
    wp = 1'b1;
    adp_u.write_field(2);
    axi_write(`GS_CTRL_OFS, 32'h2, OK);
    wp = 1'b0;
    lock_exp = 1'b0;
    adp_u.read_field(150);
    axi_write(`GS_CTRL_OFS, 32'h3, OK);
    fork
      adp_u.overlap(150);
      stat_at(20, 32'h4, 32'h4);
    join
    axi_read(`GS_LCNT_OFS, rd, OK);
    chk_word("lock_cnt2", 32'h1, rd);
    axi_read(`GS_WCNT_OFS, rd, OK);
    chk_word("wr_cnt2", 32'h2, rd);
    // Byte lane 0 off: the control word must not change
    axi_write(`GS_CTRL_OFS, 32'h0, OK, 4'hE);
    axi_read(`GS_CTRL_OFS, rd, OK, 3);
    chk_word("ctrl_strb", 32'h3, rd);
    axi_write(`GS_CTRL_OFS, 32'h0, OK);
    axi_read(`GS_CTRL_OFS, rd, OK);
    chk_word("ctrl_wr", 32'h0, rd);
    // Reset in mid-run must restore control and clear both counters
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    axi_read(`GS_CTRL_OFS, rd, OK);
    chk_word("ctrl_rst2", 32'h3, rd);
    axi_read(`GS_LCNT_OFS, rd, OK);
    chk_word("lock_rst2", 32'h0, rd);
    axi_read(`GS_WCNT_OFS, rd, OK);
    chk_word("wr_rst2", 32'h0, rd);
    repeat (10) @(posedge sys_clk);
    report_and_stop();
  end
endmodule
